// File: hdl/qpc_map.svh
// register map, reset values and timing counts of the pot control block
`ifndef QPC_MAP_SVH
`define QPC_MAP_SVH

`define QPC_OFS_POT0      4'h0
`define QPC_OFS_POT3      4'h3
`define QPC_OFS_GP2       4'h6
`define QPC_OFS_RSVD      4'h7
`define QPC_OFS_ACR       4'h8
`define QPC_PTR_ONE       4'h1

`define QPC_ACR_RST       8'h40
`define QPC_WIPER_RST     7'h40
`define QPC_WIPER_OFF     7'h00
`define QPC_BYTE_ZERO     8'h00

`define QPC_DEV_ID        4'ha
`define QPC_BIT_FULL      4'h8
`define QPC_BIT_ZERO      4'h0
`define QPC_BIT_ONE       4'h1

`define QPC_SYNC_RST      6'h38
`define QPC_RECALL_ZERO   3'h0
`define QPC_RECALL_FIRST  3'h1
`define QPC_RECALL_LAST   3'h4
`define QPC_RECALL_END    3'h5
`define QPC_RECALL_ONE    3'h1

`define QPC_NV_WRITE_MS   20
`define QPC_CLK_KHZ       10000
`define QPC_NV_CNT_W      18
`define QPC_NV_CNT_ZERO   18'h00000
`define QPC_NV_CNT_ONE    18'h00001

`endif

// File: hdl/qpc_pkg.sv
// types shared by the pot control block
package qpc_pkg;

	typedef struct packed {
		logic       volatile_select;
		logic       power_down_ctl;
		logic       nv_write_pending;
		logic [4:0] zero;
	} qpc_acr_type;

	typedef logic [3:0][6:0] qpc_wipers_type;

	typedef enum logic [8:0] {
		ST_IDLE    = 9'b000000001,
		ST_DEV     = 9'b000000010,
		ST_DEV_ACK = 9'b000000100,
		ST_REG     = 9'b000001000,
		ST_REG_ACK = 9'b000010000,
		ST_WR      = 9'b000100000,
		ST_WR_ACK  = 9'b001000000,
		ST_RD      = 9'b010000000,
		ST_RD_ACK  = 9'b100000000
	} qpc_state_type;

endpackage

// File: hdl/qpc_nvmem.sv
// non-volatile register array: initial values and general stores
`timescale 1ns/1ps
module qpc_nvmem (
	input  wire logic       clk,
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [2:0] rd_addr,
	output logic      [7:0] rd_data
);
	// contents survive reset on purpose: this models the retained array
	logic [7:0] mem [0:7];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule // qpc_nvmem

// File: hdl/qpc_top.sv
// quad pot register bank with serial slave, recall, shutdown and write interlock
// Function
// - each pot tap follows its seven-bit wiper
// - higher code moves tap monotonically toward supply
// - wipers forced to 40h during power-up
// - stored initial values recalled into wipers
// - addresses 0 to 3 select pots 0-3
// - three non-volatile general stores at 4-6
// - access control at 8, 7 reserved
// - control bit 7 picks wiper or initial
// - select 0 reaches initial, 1 wiper only
// - initial value writes also load the wiper
// - volatile select resets to zero
// - power-down bit resets high, zero shuts down
// - pin AND bit required for normal run
// - shutdown opens arrays, grounds wipers, keeps settings
// - registers stay accessible during shutdown
// - write-pending bit is read-only status
// - pending write blocks wiper and control writes
// - data sampled on rising, driven after falling
// - strap pins form low address bits
// - pointer increments, wraps from 8 to 0
// - non-volatile cycle starts only after stop
`timescale 1ns/1ps
`include "qpc_map.svh"
module qpc_top #(
	parameter int unsigned NV_WRITE_CYCLES = `QPC_NV_WRITE_MS * `QPC_CLK_KHZ
) (
	input  wire logic            CLK,
	input  wire logic            RST_N,
	input  wire logic            SCL,
	input  wire logic            SDA_IN,
	input  wire logic [2:0]      ADDR_STRAP,
	input  wire logic            PWR_DOWN_N,
	output logic                 SDA_OUT,
	output logic                 SDA_OE,
	output qpc_pkg::qpc_wipers_type WIPER,
	output logic                 RES_OPEN
);
	import qpc_pkg::*;

	localparam logic [`QPC_NV_CNT_W-1:0] NV_LOAD = (`QPC_NV_CNT_W)'(NV_WRITE_CYCLES - 1);

	function automatic logic is_pot(input logic [3:0] a);
		is_pot = (a <= `QPC_OFS_POT3);
	endfunction

	// stores end at 6, 7 reserved, control at 8
	function automatic logic is_nv(input logic [3:0] a);
		is_nv = (a <= `QPC_OFS_GP2);
	endfunction

	logic [7:0]          scl_shift_ff;
	logic [5:0]          meta_ff;
	logic [5:0]          sync_ff;
	logic                scl_d_ff;
	logic                sda_d_ff;
	qpc_state_type       st_ff;
	logic [3:0]          bit_cnt_ff;
	logic [3:0]          ptr_ff;
	logic                rw_ff;
	logic                ack_ff;
	logic [7:0]          tx_ff;
	logic                sda_oe_ff;
	logic                sda_out_ff;
	qpc_wipers_type      wr_ff;
	qpc_wipers_type      wiper_out_ff;
	logic                res_open_ff;
	qpc_acr_type         acr_ff;
	logic                nv_pend_ff;
	logic [`QPC_NV_CNT_W-1:0] nv_cnt_ff;
	logic [2:0]          rc_cnt_ff;
	logic [7:0]          mem_rdata;
	logic [2:0]          mem_raddr;
	logic                mem_we;
	logic                scl_s;
	logic                sda_s;
	logic                pd_s;
	logic [2:0]          strap_s;
	logic                scl_rise;
	logic                scl_fall;
	logic                start_ev;
	logic                stop_ev;
	logic                byte_done;
	logic                wr_strobe;
	logic                recall_done;
	logic                shut;
	logic [7:0]          rd_byte;
	logic [3:0]          nxt_ptr;
	logic [1:0]          rc_idx;

	// link side captures data on rising serial clock; stable while clock is low
	always_ff @(posedge SCL) begin
		scl_shift_ff <= {scl_shift_ff[6:0], SDA_IN};
	end

	// pins cross into the system clock through two flops
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meta_ff <= `QPC_SYNC_RST;
			sync_ff <= `QPC_SYNC_RST;
		end else begin
			meta_ff <= {SCL, SDA_IN, PWR_DOWN_N, ADDR_STRAP};
			sync_ff <= meta_ff;
		end
	end

	assign scl_s   = sync_ff[5];
	assign sda_s   = sync_ff[4];
	assign pd_s    = sync_ff[3];
	assign strap_s = sync_ff[2:0];

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	assign scl_rise    = scl_s & ~scl_d_ff;
	assign scl_fall    = ~scl_s & scl_d_ff;
	assign start_ev    = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign stop_ev     = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	assign byte_done   = scl_fall & (bit_cnt_ff == `QPC_BIT_FULL);
	assign wr_strobe   = (st_ff == ST_WR) & byte_done;
	assign recall_done = (rc_cnt_ff == `QPC_RECALL_END);
	assign nxt_ptr     = (ptr_ff >= `QPC_OFS_ACR) ? `QPC_OFS_POT0 : ptr_ff + `QPC_PTR_ONE;
	assign rc_idx      = 2'(rc_cnt_ff - `QPC_RECALL_ONE);
	// pin and bit are ANDed; either low shuts down
	assign shut        = ~(pd_s & acr_ff.power_down_ctl);
	assign mem_raddr   = recall_done ? ptr_ff[2:0] : {1'b0, rc_cnt_ff[1:0]};
	// initial values only reach the bus while volatile select is low
	// an initial value write also lands in the wiper
	assign mem_we      = wr_strobe & ~acr_ff.nv_write_pending & is_nv(ptr_ff) & ~(is_pot(ptr_ff) & acr_ff.volatile_select);

	// read data picked by address and volatile select
	always_comb begin
		rd_byte = `QPC_BYTE_ZERO;
		if (ptr_ff == `QPC_OFS_ACR) begin
			// low five bits read as zero
			rd_byte = {acr_ff.volatile_select, acr_ff.power_down_ctl, acr_ff.nv_write_pending, 5'h00};
		end else if (is_pot(ptr_ff) && acr_ff.volatile_select) begin
			rd_byte = {1'b0, wr_ff[ptr_ff[1:0]]};
		end else if (is_nv(ptr_ff)) begin
			rd_byte = mem_rdata;
		end
	end

	qpc_nvmem u_nvmem (
		.clk     (CLK),
		.wr_en   (mem_we),
		.wr_addr (ptr_ff[2:0]),
		.wr_data (scl_shift_ff),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	// recall walks the four initial values once after reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rc_cnt_ff <= `QPC_RECALL_ZERO;
		end else if (!recall_done) begin
			rc_cnt_ff <= rc_cnt_ff + `QPC_RECALL_ONE;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wr_ff <= {4{`QPC_WIPER_RST}};
		end else if (rc_cnt_ff >= `QPC_RECALL_FIRST && rc_cnt_ff <= `QPC_RECALL_LAST) begin
			wr_ff[rc_idx] <= mem_rdata[6:0];
		end else if (wr_strobe && !acr_ff.nv_write_pending && is_pot(ptr_ff)) begin
			wr_ff[ptr_ff[1:0]] <= scl_shift_ff[6:0];
		end
	end

	// control register defaults; status and zero bits not writable
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			acr_ff.volatile_select  <= 1'(`QPC_ACR_RST >> 7);
			acr_ff.power_down_ctl <= 1'b1;
			acr_ff.zero <= 5'h00;
		end else if (wr_strobe && !acr_ff.nv_write_pending && ptr_ff == `QPC_OFS_ACR) begin
			acr_ff.volatile_select  <= scl_shift_ff[7];
			acr_ff.power_down_ctl <= scl_shift_ff[6];
		end
	end

	// the timed cycle is armed by stop; clears the flag when it ends
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			nv_pend_ff <= 1'b0;
			acr_ff.nv_write_pending <= 1'b0;
			nv_cnt_ff  <= `QPC_NV_CNT_ZERO;
		end else begin
			if (mem_we) begin
				nv_pend_ff <= 1'b1;
			end else if (stop_ev && nv_pend_ff) begin
				nv_pend_ff <= 1'b0;
			end
			if (stop_ev && nv_pend_ff && !acr_ff.nv_write_pending) begin
				acr_ff.nv_write_pending <= 1'b1;
				nv_cnt_ff  <= NV_LOAD;
			end else if (acr_ff.nv_write_pending) begin
				if (nv_cnt_ff == `QPC_NV_CNT_ZERO) begin
					acr_ff.nv_write_pending <= 1'b0;
				end else begin
					nv_cnt_ff <= nv_cnt_ff - `QPC_NV_CNT_ONE;
				end
			end
		end
	end

	// shutdown grounds each wiper but keeps the register; tap is the code itself
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_wiper
			always_ff @(posedge CLK) begin
				if (!RST_N) begin
					wiper_out_ff[gi] <= `QPC_WIPER_RST;
				end else begin
					wiper_out_ff[gi] <= shut ? `QPC_WIPER_OFF : wr_ff[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			res_open_ff <= 1'b0;
			sda_out_ff  <= 1'b0;
		end else begin
			res_open_ff <= shut;
			sda_out_ff  <= 1'b0;
		end
	end

	// bit counter counts rising edges inside a byte
	always_ff @(posedge CLK) begin
		if (!RST_N || start_ev || stop_ev) begin
			bit_cnt_ff <= `QPC_BIT_ZERO;
		end else if (scl_fall && st_ff != ST_DEV && st_ff != ST_REG
			&& st_ff != ST_WR && st_ff != ST_RD) begin
			bit_cnt_ff <= `QPC_BIT_ZERO;
		end else if (byte_done) begin
			bit_cnt_ff <= `QPC_BIT_ZERO;
		end else if (scl_rise) begin
			bit_cnt_ff <= bit_cnt_ff + `QPC_BIT_ONE;
		end
	end

	// pointer loads from address byte, steps after each data byte
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ptr_ff <= `QPC_OFS_POT0;
		end else if (st_ff == ST_REG && byte_done) begin
			ptr_ff <= scl_shift_ff[3:0];
		end else if ((st_ff == ST_WR || st_ff == ST_RD) && byte_done) begin
			ptr_ff <= nxt_ptr;
		end
	end

	// the serial engine does not look at shutdown; drives after falling edges
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_ff     <= ST_IDLE;
			sda_oe_ff <= 1'b0;
			rw_ff     <= 1'b0;
			ack_ff    <= 1'b0;
			tx_ff     <= `QPC_BYTE_ZERO;
		end else if (!recall_done || stop_ev) begin
			// start is ignored until recall finishes
			st_ff     <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else if (start_ev) begin
			st_ff     <= ST_DEV;
			sda_oe_ff <= 1'b0;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					sda_oe_ff <= 1'b0;
				end
				ST_DEV: begin
					if (byte_done) begin
						// strap pins supply the low address bits
						if (scl_shift_ff[7:1] == {`QPC_DEV_ID, strap_s}) begin
							st_ff     <= ST_DEV_ACK;
							sda_oe_ff <= 1'b1;
							rw_ff     <= scl_shift_ff[0];
						end else begin
							st_ff <= ST_IDLE;
						end
					end
				end
				ST_DEV_ACK: begin
					if (scl_fall) begin
						if (rw_ff) begin
							st_ff     <= ST_RD;
							sda_oe_ff <= ~rd_byte[7];
							tx_ff     <= {rd_byte[6:0], 1'b0};
						end else begin
							st_ff     <= ST_REG;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ST_REG: begin
					if (byte_done) begin
						st_ff     <= ST_REG_ACK;
						sda_oe_ff <= 1'b1;
					end
				end
				ST_WR: begin
					if (byte_done) begin
						st_ff     <= ST_WR_ACK;
						sda_oe_ff <= 1'b1;
					end
				end
				ST_REG_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						st_ff     <= ST_WR;
						sda_oe_ff <= 1'b0;
					end
				end
				ST_RD: begin
					if (byte_done) begin
						st_ff     <= ST_RD_ACK;
						sda_oe_ff <= 1'b0;
					end else if (scl_fall) begin
						sda_oe_ff <= ~tx_ff[7];
						tx_ff     <= {tx_ff[6:0], 1'b0};
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						ack_ff <= ~sda_s;
					end else if (scl_fall) begin
						if (ack_ff) begin
							st_ff     <= ST_RD;
							sda_oe_ff <= ~rd_byte[7];
							tx_ff     <= {rd_byte[6:0], 1'b0};
						end else begin
							st_ff <= ST_IDLE;
						end
					end
				end
				default: begin
					st_ff     <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	assign SDA_OUT  = sda_out_ff;
	assign SDA_OE   = sda_oe_ff;
	assign WIPER    = wiper_out_ff;
	assign RES_OPEN = res_open_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_wiper_preset;
		!$past(RST_N) |-> (wr_ff[0] == `QPC_WIPER_RST) && (wr_ff[3] == `QPC_WIPER_RST);
	endproperty
	a_wiper_preset: assert property (p_wiper_preset) else $error("wiper not preset");

	property p_ctl_default;
		!$past(RST_N) |-> acr_ff.power_down_ctl && !acr_ff.volatile_select && !acr_ff.nv_write_pending;
	endproperty
	a_ctl_default: assert property (p_ctl_default) else $error("control default wrong");

	property p_shut_ground;
		shut |=> (WIPER == '0) && RES_OPEN;
	endproperty
	a_shut_ground: assert property (p_shut_ground) else $error("shutdown wiper not low");

	property p_run_follow;
		!shut && $stable(wr_ff) |=> WIPER == $past(wr_ff);
	endproperty
	a_run_follow: assert property (p_run_follow) else $error("wiper not following");

	property p_wip_block;
		wr_strobe && acr_ff.nv_write_pending |=> $stable(wr_ff) && acr_ff.volatile_select == $past(acr_ff.volatile_select);
	endproperty
	a_wip_block: assert property (p_wip_block) else $error("write taken during wip");

	property p_wip_ro;
		wr_strobe && ptr_ff == `QPC_OFS_ACR && !acr_ff.nv_write_pending |=> !acr_ff.nv_write_pending;
	endproperty
	a_wip_ro: assert property (p_wip_ro) else $error("pending bit written");
	property p_ptr_wrap;
		wr_strobe && ptr_ff == `QPC_OFS_ACR |=> ptr_ff == `QPC_OFS_POT0;
	endproperty
	a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

	property p_wip_after_stop;
		$rose(acr_ff.nv_write_pending) |-> $past(stop_ev) && $past(nv_pend_ff);
	endproperty
	a_wip_after_stop: assert property (p_wip_after_stop) else $error("wip without stop");

	property p_wip_end;
		acr_ff.nv_write_pending && nv_cnt_ff == `QPC_NV_CNT_ZERO |=> !acr_ff.nv_write_pending;
	endproperty
	a_wip_end: assert property (p_wip_end) else $error("wip stuck");

	property p_iv_copy;
		mem_we && is_pot(ptr_ff) |=> wr_ff[$past(ptr_ff[1:0])] == $past(scl_shift_ff[6:0]);
	endproperty
	a_iv_copy: assert property (p_iv_copy) else $error("initial write missed wiper");

	property p_addr_match;
		st_ff == ST_DEV ##1 st_ff == ST_DEV_ACK |-> $past(scl_shift_ff[3:1]) == $past(strap_s);
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("ack on wrong address");

	c_nv_cycle: cover property ($rose(acr_ff.nv_write_pending));
	c_shutdown: cover property ($rose(RES_OPEN));
	c_read: cover property (st_ff == ST_RD_ACK ##[1:200] st_ff == ST_RD);
endmodule // qpc_top

// File: tb/qpc_i2c_master.sv
// serial bus master model for the pot control bench
`timescale 1ns/1ps
module qpc_i2c_master (
	output logic      scl,
	output logic      pull,
	input  wire logic sda
);
	// half period of the serial clock; the slave needs four system clocks per level
	localparam int H = 600;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic bit_x(input logic b, output logic r);
		#100 pull = !b;
		#(H - 100) scl = 1'b1;
		r = sda;
		#H scl = 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ack_in, ack);
	endtask
	// odd offset keeps the link edges away from the system clock edges
	task automatic start();
		#37 pull = 1'b1;
		#H scl = 1'b0;
	endtask
	task automatic restart();
		#100 pull = 1'b0;
		#(H - 100) scl = 1'b1;
		#H pull = 1'b1;
		#H scl = 1'b0;
	endtask
	task automatic stop();
		#100 pull = 1'b1;
		#(H - 100) scl = 1'b1;
		#H pull = 1'b0;
		#H;
	endtask
endmodule // qpc_i2c_master

// File: tb/qpc_top_tb.sv
// self-checking bench for the pot control block
`timescale 1ns/1ps
module qpc_top_tb;
	import qpc_pkg::*;
	localparam int NV_CYC = 2000;
	logic           clk, rst_n, pwr_down_n, sda_out, sda_oe, res_open, scl, pull, ack;
	logic [2:0]     strap;
	qpc_wipers_type wiper;
	logic [7:0]     rd [0:3];
	logic [7:0]     nv [0:6] = '{8'h2a, 8'h00, 8'h55, 8'h7f, 8'ha5, 8'h5a, 8'hc3};
	int             n_fail = 0;
	int             compares = 0;
	// open drain line with pull-up
	wire sda = !((sda_oe && !sda_out) || pull);

	qpc_top #(.NV_WRITE_CYCLES(NV_CYC)) u_dut (
		.CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda), .ADDR_STRAP(strap),
		.PWR_DOWN_N(pwr_down_n), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .WIPER(wiper),
		.RES_OPEN(res_open)
	);
	qpc_i2c_master u_mst (.scl(scl), .pull(pull), .sda(sda));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] addr, input logic [31:0] d, input int n);
		logic [7:0] q;
		u_mst.start();
		u_mst.byte_x({4'ha, strap, 1'b0}, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h00);
		u_mst.byte_x(addr, 1'b1, q, ack);
		for (int i = 0; i < n; i++) u_mst.byte_x(d[8*i +: 8], 1'b1, q, ack);
		u_mst.stop();
	endtask
	task automatic reg_rd(input logic [7:0] addr, input int n);
		logic [7:0] q;
		u_mst.start();
		u_mst.byte_x({4'ha, strap, 1'b0}, 1'b1, q, ack);
		u_mst.byte_x(addr, 1'b1, q, ack);
		u_mst.restart();
		u_mst.byte_x({4'ha, strap, 1'b1}, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h00);
		for (int i = 0; i < n; i++) u_mst.byte_x(8'hff, (i == n - 1), rd[i], ack);
		u_mst.stop();
	endtask
	task automatic do_reset();
		@(negedge clk) rst_n = 1'b0;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 4; i++) chk({1'b0, wiper[i]}, 8'h40);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
	endtask
	task automatic nv_wait();
		repeat (NV_CYC + 100) @(negedge clk);
	endtask

	task automatic t_nv();
		for (int i = 0; i < 7; i++) begin
			reg_wr(8'(i), {24'h0, nv[i]}, 1);
			if (i < 4) chk({1'b0, wiper[i]}, nv[i]);
			if (i == 0) begin
				reg_wr(8'h08, 32'h80, 1);
				reg_rd(8'h08, 1);
				chk(rd[0], 8'h60);
			end
			nv_wait();
		end
		reg_rd(8'h08, 1);
		chk(rd[0], 8'h40);
		$display("test nv_store done");
	endtask
	task automatic t_recall();
		do_reset();
		for (int i = 0; i < 4; i++) chk({1'b0, wiper[i]}, nv[i]);
		reg_rd(8'h08, 1);
		chk(rd[0], 8'h40);
		reg_wr(8'h08, 32'hff, 1);
		reg_rd(8'h08, 1);
		chk(rd[0], 8'hc0);
		$display("test recall done");
	endtask
	task automatic t_vol();
		logic [7:0] w [0:3] = '{8'h33, 8'h40, 8'h10, 8'h7f};
		reg_wr(8'h00, 32'h7f104001, 4);
		chk({1'b0, wiper[0]}, 8'h01);
		reg_wr(8'h08, 32'h33c0, 2);
		reg_rd(8'h00, 4);
		for (int i = 0; i < 4; i++) chk(rd[i], w[i]);
		for (int i = 0; i < 4; i++) chk({1'b0, wiper[i]}, w[i]);
		reg_wr(8'h08, 32'h40, 1);
		reg_rd(8'h00, 1);
		chk(rd[0], nv[0]);
		reg_rd(8'h04, 3);
		for (int i = 0; i < 3; i++) chk(rd[i], nv[4 + i]);
		reg_rd(8'h07, 3);
		chk(rd[0], 8'h00);
		chk(rd[1], 8'h40);
		chk(rd[2], nv[0]);
		$display("test select done");
	endtask
	task automatic t_power_down_ctl();
		reg_wr(8'h08, 32'hc0, 1);
		@(negedge clk) pwr_down_n = 1'b0;
		repeat (10) @(negedge clk);
		chk({7'h00, res_open}, 8'h01);
		for (int i = 0; i < 4; i++) chk({1'b0, wiper[i]}, 8'h00);
		reg_wr(8'h02, 32'h11, 1);
		reg_rd(8'h02, 1);
		chk(rd[0], 8'h11);
		@(negedge clk) pwr_down_n = 1'b1;
		repeat (10) @(negedge clk);
		chk({7'h00, res_open}, 8'h00);
		chk({1'b0, wiper[2]}, 8'h11);
		reg_wr(8'h08, 32'h80, 1);
		repeat (10) @(negedge clk);
		chk({7'h00, res_open}, 8'h01);
		reg_wr(8'h08, 32'hc0, 1);
		repeat (10) @(negedge clk);
		chk({7'h00, res_open}, 8'h00);
		$display("test shutdown done");
	endtask
	task automatic t_id();
		logic [7:0] q;
		@(negedge clk) strap = 3'h2;
		repeat (10) @(negedge clk);
		u_mst.start();
		u_mst.byte_x({4'ha, 3'h5, 1'b0}, 1'b1, q, ack);
		chk({7'h00, ack}, 8'h01);
		u_mst.stop();
		reg_rd(8'h08, 1);
		chk(rd[0], 8'hc0);
		$display("test address done");
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#6000000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		pwr_down_n = 1'b1;
		strap = 3'h5;
		// the array starts unknown, so the first recall is not judged
		do_reset();
		t_nv();
		t_recall();
		t_vol();
		t_power_down_ctl();
		t_id();
		tally_and_finish();
	end
endmodule // qpc_top_tb
